// ### phy_ctrl_consts.svh
/*
  Offsets, field positions, reset values and timing figures of the
  upper control bits of the first PHY control register.
  Assumes a 10 MHz mclk and a word-indexed AXI4-Lite map.
*/
`ifndef PHY_CTRL_CONSTS_SVH
`define PHY_CTRL_CONSTS_SVH

`define MCLK_PERIOD_NS 100
`define LOSS_TIME_NS 250000
`define RECOVERY_TIME_US 3000
`define MDIX_SLOT_US 1000
`define MDIX_FAST_SLOT_US 100

`define CTRL1_IDX 8'h09
`define STATUS_IDX 8'h10
`define CTRL1_RESET 16'h0000
`define CTRL1_RW_MASK 16'h03E0
`define ENH_BIT 9
`define TDR_BIT 8
`define LLR_BIT 7
`define FAST_BIT 6
`define ROBUST_BIT 5
`define STAT_LINK_BIT 0
`define STAT_MDIX_BIT 1

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define RXD_FALSE_CODE 4'h2
`define RXD_ERR_FILL 4'h1
`define STRAP_SETTLE 2'h2
`define LFSR_SEED 11'h001

`endif

// ### phy_ctrl_pkg.sv
/*
  Types used by the control-one register block; its crossover unit uses none of them.
  Assumes nothing of its surroundings.
*/
package phy_ctrl_pkg;
  typedef enum logic [2:0] {RX_IDLE, RX_PASS, RX_FALSE, RX_ERRFILL, RX_SQUELCH} rx_state_e;
  typedef enum logic [1:0] {LNK_DOWN, LNK_UP, LNK_GRACE, LNK_HOLD} link_state_e;
  typedef logic [15:0] reg16_t;
endpackage

// ### mdix_resolver.sv
/*
  Automatic MDI/MDIX pair selection with randomised slot decisions.
  Assumes link status and mode inputs from logic on mclk.
*/
`include "phy_ctrl_consts.svh"

module mdix_resolver #(
  parameter int SLOT_CYC = 10000,
  parameter int FAST_CYC = 1000
)(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic autoEn,
  input wire logic fastEn,
  input wire logic forced100,
  input wire logic linkUp,
  output logic mdix
);
  localparam int CNT_W = 24;
  localparam int FAST_LAST = FAST_CYC - 1;
  logic [CNT_W-1:0] cnt_r, cnt_nxt, limit;
  logic [10:0] lfsr_r, lfsr_nxt;
  logic mdix_r, mdix_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    mdix_nxt = mdix_r;
    lfsr_nxt = {lfsr_r[9:0], lfsr_r[10] ^ lfsr_r[8]};
    // Shortened slot only for forced 100BASE-TX partners
    limit = (fastEn && forced100) ? CNT_W'(FAST_CYC - 1) : CNT_W'(SLOT_CYC - 1);
    if (!autoEn) begin
      cnt_nxt = '0;
      mdix_nxt = 1'b0;
    end else if (linkUp) begin
      cnt_nxt = '0;
    end else if (cnt_r >= limit) begin
      cnt_nxt = '0;
      // Random toggle breaks lock-step between two identical ends
      if (lfsr_r[0]) begin
        mdix_nxt = ~mdix_r;
      end
    end else begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cnt_r <= '0;
      mdix_r <= 1'b0;
      lfsr_r <= `LFSR_SEED;
    end else begin
      cnt_r <= cnt_nxt;
      mdix_r <= mdix_nxt;
      lfsr_r <= lfsr_nxt;
    end
  end

  assign mdix = mdix_r;

  mdix_off_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !autoEn |=> !mdix_r) else $error("crossover active while disabled");
  mdix_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (autoEn && linkUp) |=> $stable(mdix_r)) else $error("pair swap with link up");
  fast_slot_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (autoEn && fastEn && forced100 && !linkUp && cnt_r == FAST_LAST) |=> cnt_r == 0)
    else $error("fast slot length wrong");
endmodule

// ### phy_control_one.sv
/*
  Upper bits of the first PHY control register with the receive signalling,
  link loss timing, cable diagnostic trigger and crossover control they steer.
  Assumes AXI4-Lite on mclk, receive and line status from logic on mclk,
  strap pins asynchronous.
*/
`include "phy_ctrl_consts.svh"

module phy_control_one #(
  parameter int ADDR_W = 8,
  parameter int HOLD_CYC = `RECOVERY_TIME_US * 1000 / `MCLK_PERIOD_NS,
  parameter int SLOT_CYC = `MDIX_SLOT_US * 1000 / `MCLK_PERIOD_NS,
  parameter int FAST_CYC = `MDIX_FAST_SLOT_US * 1000 / `MCLK_PERIOD_NS
)(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic rxActive,
  input wire logic falseCarrier,
  input wire logic symbolError,
  input wire logic [3:0] rxNibble,
  output logic crsDv,
  output logic rxEr,
  output logic [3:0] rxd,
  input wire logic signalOk,
  input wire logic forced100,
  output logic linkUp,
  output logic tdrStart,
  output logic mdixSel,
  input wire logic strap100Pin,
  input wire logic strapMdixPin
);
  localparam int LOSS_CYC = `LOSS_TIME_NS / `MCLK_PERIOD_NS;
  localparam int CNT_W = 24;

  function automatic logic [7:0] wordIdx(input logic [ADDR_W-1:0] a);
    return 8'(a >> 2);
  endfunction

  // Bus slave state
  logic awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt, bvalid_r, bvalid_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [7:0] awIdx_r, awIdx_nxt;
  logic [15:0] wData_r, wData_nxt;
  logic [1:0] wStrb_r, wStrb_nxt, bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  phy_ctrl_pkg::reg16_t ctrl_r, ctrl_nxt, laneMask;

  // Strap capture
  logic s100Meta_r, s100_r, sMdixMeta_r, sMdix_r;
  logic [1:0] strapCnt_r, strapCnt_nxt;

  // Receive and link state
  phy_ctrl_pkg::rx_state_e rxSt_r, rxSt_nxt;
  phy_ctrl_pkg::link_state_e linkSt_r, linkSt_nxt;
  logic [CNT_W-1:0] linkCnt_r, linkCnt_nxt;
  logic crsDv_r, crsDv_nxt, rxEr_r, rxEr_nxt, linkUp_r, linkUp_nxt;
  logic tdrStart_r, tdrStart_nxt, mdixNow;
  logic [3:0] rxd_r, rxd_nxt;
  logic enh;

  assign enh = ctrl_r[`ENH_BIT];
  assign awready = !awHeld_r && !bvalid_r;
  assign wready = !wHeld_r && !bvalid_r;
  assign arready = !rvalid_r;
  assign laneMask = {{8{wStrb_r[1]}}, {8{wStrb_r[0]}}} & `CTRL1_RW_MASK;

  always_comb begin
    awHeld_nxt = awHeld_r;
    awIdx_nxt = awIdx_r;
    wHeld_nxt = wHeld_r;
    wData_nxt = wData_r;
    wStrb_nxt = wStrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    ctrl_nxt = ctrl_r;
    strapCnt_nxt = (strapCnt_r == 2'h3) ? strapCnt_r : strapCnt_r + 2'h1;
    if (awvalid && awready) begin
      awHeld_nxt = 1'b1;
      awIdx_nxt = wordIdx(awaddr);
    end
    if (wvalid && wready) begin
      wHeld_nxt = 1'b1;
      wData_nxt = wdata[15:0];
      wStrb_nxt = wstrb[1:0];
    end
    // Address and data may arrive in either order
    if (awHeld_r && wHeld_r) begin
      awHeld_nxt = 1'b0;
      wHeld_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = `RESP_SLVERR;
      if (awIdx_r == `CTRL1_IDX) begin
        ctrl_nxt = (ctrl_r & ~laneMask) | (wData_r & laneMask);
        bresp_nxt = `RESP_OKAY;
      end else if (awIdx_r == `STATUS_IDX) begin
        bresp_nxt = `RESP_OKAY;
      end
    end
    if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
    // Strap set wins over a software write in the same cycle
    if (strapCnt_r == `STRAP_SETTLE && s100_r && sMdix_r) begin
      ctrl_nxt[`ROBUST_BIT] = 1'b1;
    end
    if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = '0;
      rresp_nxt = `RESP_OKAY;
      if (wordIdx(araddr) == `CTRL1_IDX) begin
        rdata_nxt = {16'h0000, ctrl_r};
      end else if (wordIdx(araddr) == `STATUS_IDX) begin
        rdata_nxt[`STAT_LINK_BIT] = linkUp_r;
        rdata_nxt[`STAT_MDIX_BIT] = mdixNow;
      end else begin
        rresp_nxt = `RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      awHeld_r <= 1'b0;
      awIdx_r <= 8'h00;
      wHeld_r <= 1'b0;
      wData_r <= 16'h0000;
      wStrb_r <= 2'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= `RESP_OKAY;
      ctrl_r <= `CTRL1_RESET;
      strapCnt_r <= 2'h0;
      s100Meta_r <= 1'b0;
      s100_r <= 1'b0;
      sMdixMeta_r <= 1'b0;
      sMdix_r <= 1'b0;
    end else begin
      awHeld_r <= awHeld_nxt;
      awIdx_r <= awIdx_nxt;
      wHeld_r <= wHeld_nxt;
      wData_r <= wData_nxt;
      wStrb_r <= wStrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      ctrl_r <= ctrl_nxt;
      strapCnt_r <= strapCnt_nxt;
      s100Meta_r <= strap100Pin;
      s100_r <= s100Meta_r;
      sMdixMeta_r <= strapMdixPin;
      sMdix_r <= sMdixMeta_r;
    end
  end

  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  // Receive signalling toward the MAC
  always_comb begin
    rxSt_nxt = rxSt_r;
    unique case (rxSt_r)
      phy_ctrl_pkg::RX_IDLE, phy_ctrl_pkg::RX_PASS: begin
        if (falseCarrier && rxSt_r == phy_ctrl_pkg::RX_IDLE) begin
          rxSt_nxt = enh ? phy_ctrl_pkg::RX_SQUELCH : phy_ctrl_pkg::RX_FALSE;
        end else if (symbolError) begin
          rxSt_nxt = enh ? phy_ctrl_pkg::RX_SQUELCH : phy_ctrl_pkg::RX_ERRFILL;
        end else begin
          rxSt_nxt = phy_ctrl_pkg::RX_PASS;
        end
      end
      phy_ctrl_pkg::RX_FALSE, phy_ctrl_pkg::RX_ERRFILL, phy_ctrl_pkg::RX_SQUELCH: begin
        rxSt_nxt = rxSt_r;
      end
    endcase
    // Every state lasts only until the receive event ends
    if (!rxActive) begin
      rxSt_nxt = phy_ctrl_pkg::RX_IDLE;
    end
    crsDv_nxt = rxActive && (rxSt_nxt != phy_ctrl_pkg::RX_SQUELCH);
    rxEr_nxt = (rxSt_nxt == phy_ctrl_pkg::RX_FALSE) ||
               (rxSt_nxt == phy_ctrl_pkg::RX_ERRFILL && symbolError);
    rxd_nxt = 4'h0;
    unique case (rxSt_nxt)
      phy_ctrl_pkg::RX_FALSE: rxd_nxt = `RXD_FALSE_CODE;
      phy_ctrl_pkg::RX_ERRFILL: rxd_nxt = `RXD_ERR_FILL;
      phy_ctrl_pkg::RX_PASS: rxd_nxt = rxNibble;
      phy_ctrl_pkg::RX_IDLE, phy_ctrl_pkg::RX_SQUELCH: rxd_nxt = 4'h0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rxSt_r <= phy_ctrl_pkg::RX_IDLE;
      crsDv_r <= 1'b0;
      rxEr_r <= 1'b0;
      rxd_r <= 4'h0;
    end else begin
      rxSt_r <= rxSt_nxt;
      crsDv_r <= crsDv_nxt;
      rxEr_r <= rxEr_nxt;
      rxd_r <= rxd_nxt;
    end
  end

  // Link status with optional recovery hold
  always_comb begin
    linkSt_nxt = linkSt_r;
    linkCnt_nxt = linkCnt_r + 1'b1;
    unique case (linkSt_r)
      phy_ctrl_pkg::LNK_DOWN: begin
        linkCnt_nxt = '0;
        if (signalOk) begin
          linkSt_nxt = phy_ctrl_pkg::LNK_UP;
        end
      end
      phy_ctrl_pkg::LNK_UP: begin
        linkCnt_nxt = '0;
        if (!signalOk) begin
          linkSt_nxt = phy_ctrl_pkg::LNK_GRACE;
        end
      end
      phy_ctrl_pkg::LNK_GRACE: begin
        if (signalOk) begin
          linkSt_nxt = phy_ctrl_pkg::LNK_UP;
        end else if (linkCnt_r >= CNT_W'(LOSS_CYC - 1)) begin
          linkCnt_nxt = '0;
          linkSt_nxt = ctrl_r[`LLR_BIT] ? phy_ctrl_pkg::LNK_HOLD :
                       phy_ctrl_pkg::LNK_DOWN;
        end
      end
      phy_ctrl_pkg::LNK_HOLD: begin
        // Short interference rides through; long loss still drops
        if (signalOk) begin
          linkSt_nxt = phy_ctrl_pkg::LNK_UP;
        end else if (linkCnt_r >= CNT_W'(HOLD_CYC - 1)) begin
          linkSt_nxt = phy_ctrl_pkg::LNK_DOWN;
        end
      end
    endcase
    linkUp_nxt = linkSt_nxt != phy_ctrl_pkg::LNK_DOWN;
    tdrStart_nxt = ctrl_r[`TDR_BIT] && linkUp_r && !linkUp_nxt;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      linkSt_r <= phy_ctrl_pkg::LNK_DOWN;
      linkCnt_r <= '0;
      linkUp_r <= 1'b0;
      tdrStart_r <= 1'b0;
    end else begin
      linkSt_r <= linkSt_nxt;
      linkCnt_r <= linkCnt_nxt;
      linkUp_r <= linkUp_nxt;
      tdrStart_r <= tdrStart_nxt;
    end
  end

  mdix_resolver #(
    .SLOT_CYC(SLOT_CYC),
    .FAST_CYC(FAST_CYC)
  ) crossover (
    .mclk(mclk),
    .rst_b(rst_b),
    .autoEn(ctrl_r[`ROBUST_BIT]),
    .fastEn(ctrl_r[`FAST_BIT]),
    .forced100(forced100),
    .linkUp(linkUp_r),
    .mdix(mdixNow)
  );

  assign crsDv = crsDv_r;
  assign rxEr = rxEr_r;
  assign rxd = rxd_r;
  assign linkUp = linkUp_r;
  assign tdrStart = tdrStart_r;
  assign mdixSel = mdixNow;

  crs_normal_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (rxActive && !enh && rxSt_r == phy_ctrl_pkg::RX_PASS) |=> crsDv_r)
    else $error("carrier sense low on active line");
  false_code_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (rxSt_r == phy_ctrl_pkg::RX_FALSE) |-> (rxEr_r && rxd_r == `RXD_FALSE_CODE && crsDv_r))
    else $error("false carrier code wrong");
  enh_false_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (rxActive && enh && falseCarrier && rxSt_r == phy_ctrl_pkg::RX_IDLE)
    |=> !crsDv_r ##1 (!crsDv_r || !$past(rxActive)))
    else $error("carrier sense kept after false carrier");
  fill_one_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (rxSt_r == phy_ctrl_pkg::RX_ERRFILL) |-> (rxd_r == `RXD_ERR_FILL && crsDv_r))
    else $error("error fill value wrong");
  sym_squelch_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (rxSt_r == phy_ctrl_pkg::RX_PASS && rxActive && enh && symbolError) |=> !crsDv_r)
    else $error("carrier sense kept after symbol error");
  tdr_run_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $fell(linkUp_r) |-> (tdrStart_r == $past(ctrl_r[`TDR_BIT])))
    else $error("cable test trigger mismatch");
  recovery_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (linkSt_r == phy_ctrl_pkg::LNK_GRACE && !signalOk && ctrl_r[`LLR_BIT] &&
     linkCnt_r == CNT_W'(LOSS_CYC - 1)) |=> linkUp_r ##1 linkUp_r)
    else $error("link dropped despite recovery");
  loss_time_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (linkSt_r == phy_ctrl_pkg::LNK_GRACE && !signalOk && !ctrl_r[`LLR_BIT] &&
     linkCnt_r == CNT_W'(LOSS_CYC - 1)) |=> !linkUp_r)
    else $error("link loss timing wrong");
  strap_set_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (strapCnt_r == `STRAP_SETTLE && s100_r && sMdix_r) |=> ctrl_r[`ROBUST_BIT])
    else $error("strap did not set robust crossover");
  resv_zero_a: assert property (@(posedge mclk) disable iff (!rst_b)
    rvalid_r |-> rdata_r[31:10] == 22'h000000)
    else $error("reserved bits read nonzero");

  false_seen_c: cover property (@(posedge mclk) disable iff (!rst_b)
    rxSt_r == phy_ctrl_pkg::RX_FALSE);
  enh_error_c: cover property (@(posedge mclk) disable iff (!rst_b)
    rxSt_r == phy_ctrl_pkg::RX_PASS ##1 rxSt_r == phy_ctrl_pkg::RX_SQUELCH);
  ride_through_c: cover property (@(posedge mclk) disable iff (!rst_b)
    linkSt_r == phy_ctrl_pkg::LNK_HOLD ##1 linkSt_r == phy_ctrl_pkg::LNK_UP);
  tdr_fire_c: cover property (@(posedge mclk) disable iff (!rst_b) tdrStart_r);
endmodule

// ### line_partner.sv
/*
  Far-side model: receive events on the line and signal quality.
  Assumes a free-running mclk; callers enter its tasks at a rising edge.
*/
module line_partner (
  input wire logic mclk,
  output logic rxActive,
  output logic falseCarrier,
  output logic symbolError,
  output logic [3:0] rxNibble,
  output logic signalOk,
  output logic forced100
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    {rxActive, falseCarrier, symbolError, signalOk, forced100} = 5'h00;
    rxNibble = 4'h5;
  end

  // Kind 0 clean, 1 false carrier, 2 symbol error at errAt
  task automatic frame(input int kind, input int len, input int errAt);
    for (int i = 0; i < len; i++) begin
      @(posedge mclk);
      rxActive <= 1'b1;
      falseCarrier <= (kind == 1) && (i == 0);
      symbolError <= (kind == 2) && (i == errAt);
      rxNibble <= 4'hA ^ 4'(i);
    end
    @(posedge mclk);
    {rxActive, falseCarrier, symbolError} <= 3'h0;
    // Idle data is not held, so a stale nibble cannot pass
    rxNibble <= ~rxNibble;
  endtask

  // Caller is at a rising edge
  task automatic setLine(input logic ok, input logic f100);
    signalOk <= ok;
    forced100 <= f100;
  endtask
endmodule

// ### tb_top.sv
/*
  Self-checking bench for the control-one register block.
  Assumes the block's AXI4-Lite map and the line_partner far-side model.
*/
`include "phy_ctrl_consts.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] CTRL_A = `CTRL1_IDX << 2;
  localparam logic [7:0] STAT_A = `STATUS_IDX << 2;
  logic mclk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, crsDv, rxEr, linkUp, tdrStart, mdixSel;
  logic rxActive, falseCarrier, symbolError, signalOk, forced100, strap100Pin, strapMdixPin;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb, rxNibble, rxd;
  logic [1:0] bresp, rresp, rs;
  int errTotal = 0;
  int checks = 0;
  int cyc = 0;

  // Short counts keep the run brief
  phy_control_one #(.HOLD_CYC(20), .SLOT_CYC(40), .FAST_CYC(8)) dut (
    .mclk, .rst_b, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
    .rresp, .rxActive, .falseCarrier, .symbolError, .rxNibble, .crsDv, .rxEr, .rxd,
    .signalOk, .forced100, .linkUp, .tdrStart, .mdixSel, .strap100Pin, .strapMdixPin);

  line_partner line (.mclk, .rxActive, .falseCarrier, .symbolError, .rxNibble,
    .signalOk, .forced100);

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errTotal++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, errTotal);
    if (errTotal == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Hang guard, well above the expected run length
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errTotal++;
      tally_and_finish;
    end
  end

  task automatic doReset(input logic straps);
    @(posedge mclk);
    rst_b <= 1'b0;
    {strap100Pin, strapMdixPin} <= {straps, straps};
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (5) @(posedge mclk);
  endtask

  // Waits for the answer; only the hang guard ends a stuck transfer
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge mclk);
    {awvalid, wvalid, bready} <= 3'h7;
    {awaddr, wdata, wstrb} <= {a, d, s};
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic axiRd(input logic [7:0] a);
    @(posedge mclk);
    {arvalid, rready} <= 2'h3;
    araddr <= a;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    {rs, rd} = {rresp, rdata};
    rready <= 1'b0;
  endtask

  task automatic regCase;
    axiRd(CTRL_A);
    chk(rd, 32'h0);
    axiWr(CTRL_A, 32'hFFFFFFFF, 4'hF);
    chk(rs, `RESP_OKAY);
    axiRd(CTRL_A);
    chk(rd, 32'h3E0);
    axiWr(CTRL_A, rd & ~32'h200, 4'hF);
    axiRd(CTRL_A);
    chk(rd, 32'h1E0);
    axiWr(CTRL_A, 32'h0, 4'h1);
    axiRd(CTRL_A);
    chk(rd, 32'h100);
    axiWr(8'h30, 32'hFFFF, 4'hF);
    chk(rs, `RESP_SLVERR);
    axiRd(8'h30);
    chk({rs, rd[29:0]}, {`RESP_SLVERR, 30'h0});
    axiRd(CTRL_A);
    chk(rd, 32'h100);
    axiRd(STAT_A);
    chk({rs, rd[31:2]}, 32'h0);
    $display("test registers done");
  endtask

  task automatic rxCase(input logic enh, input int kind, input int len, input int errAt);
    logic [5:0] e;
    axiWr(CTRL_A, {22'h0, enh, 9'h0}, 4'hF);
    fork
      line.frame(kind, len, errAt);
      begin
        @(posedge mclk);
        for (int i = 0; i <= len; i++) begin
          @(posedge mclk);
          #1;
          if (i == len) e = 6'h00;
          else if (kind == 1) e = enh ? 6'h00 : 6'h32;
          else if (kind == 2 && i >= errAt) e = enh ? 6'h00 : {1'b1, i == errAt, 4'h1};
          else e = {2'h2, 4'hA ^ 4'(i)};
          chk({crsDv, rxEr, rxd}, e);
        end
      end
    join
    $display("test receive kind %0d enhanced %0d done", kind, enh);
  endtask

  task automatic linkCase(input logic [15:0] c, input int back, input int lo, input int hi,
                          input int expTdr);
    int fall, tdr;
    {fall, tdr} = 0;
    axiWr(CTRL_A, {16'h0, c}, 4'hF);
    @(posedge mclk);
    line.setLine(1'b1, 1'b0);
    repeat (4) @(posedge mclk);
    chk(linkUp, 1'b1);
    line.setLine(1'b0, 1'b0);
    for (int n = 1; n <= 2600; n++) begin
      @(posedge mclk);
      if (n == back) line.setLine(1'b1, 1'b0);
      #1;
      if (tdrStart === 1'b1) tdr++;
      if (linkUp !== 1'b1 && fall == 0) fall = n;
    end
    chk(fall >= lo && fall <= hi, 1'b1);
    chk(tdr, expTdr);
    @(posedge mclk);
    line.setLine(1'b1, 1'b0);
    repeat (4) @(posedge mclk);
    $display("test link loss ctrl %h done", c);
  endtask

  task automatic flipCount(input int n, output int f);
    logic last;
    f = 0;
    last = mdixSel;
    repeat (n) begin
      @(posedge mclk);
      #1;
      if (mdixSel !== last) f++;
      last = mdixSel;
    end
  endtask

  task automatic mdixCase;
    int f;
    @(posedge mclk);
    line.setLine(1'b0, 1'b1);
    axiWr(CTRL_A, 32'h0, 4'hF);
    flipCount(2800, f);
    chk({mdixSel, f[30:0]}, 32'h0);
    axiWr(CTRL_A, 32'h60, 4'hF);
    // A normal slot of 40 cycles allows at most 10 swaps in 400 cycles
    flipCount(400, f);
    chk(f > 10, 1'b1);
    @(posedge mclk);
    line.setLine(1'b1, 1'b1);
    repeat (4) @(posedge mclk);
    flipCount(200, f);
    chk(f, 0);
    axiRd(STAT_A);
    chk(rd, {30'h0, mdixSel, 1'b1});
    $display("test crossover done");
  endtask

  task automatic strapCase;
    doReset(1'b1);
    axiRd(CTRL_A);
    chk(rd, 32'h20);
    doReset(1'b0);
    axiRd(CTRL_A);
    chk(rd, 32'h0);
    $display("test straps done");
  endtask

  initial begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready, strap100Pin, strapMdixPin} <= 8'h00;
    {awaddr, araddr, wdata, wstrb} <= '0;
    doReset(1'b0);
    regCase;
    rxCase(1'b0, 0, 6, 0);
    rxCase(1'b0, 1, 5, 0);
    rxCase(1'b0, 2, 8, 3);
    rxCase(1'b0, 2, 6, 0);
    rxCase(1'b1, 1, 5, 0);
    rxCase(1'b1, 2, 8, 3);
    // Link drops 2500 cycles after loss is first seen, plus 20 with recovery
    linkCase(16'h0100, 0, 2501, 2501, 1);
    linkCase(16'h0000, 0, 2501, 2501, 0);
    linkCase(16'h0180, 2510, 0, 0, 0);
    linkCase(16'h0080, 0, 2521, 2521, 0);
    mdixCase;
    strapCase;
    tally_and_finish;
  end
endmodule
